// >>> bench/prog_driver.sv
// behavioural programmer driving one pin set
`timescale 1ns/1ns
module prog_driver (
  output logic entry,
  output logic pclk,
  output logic pdat
);
  // ==========================================================
  // idle: clock stands low outside frames
  initial begin
    entry = 1'b0;
    pclk = 1'b0;
    pdat = 1'b0;
  end
  // clock and data held low while the enable moves
  task automatic enter(input logic on);
    pclk = 1'b0;
    pdat = 1'b0;
    entry = on;
  endtask
  // 20 bits lsb first, bit changed after each rise, 160 ns period
  // any command, output-type ones too: the output half is not read back here
  task automatic send(input logic [3:0] cmd, input logic [15:0] opnd);
    logic [19:0] word;
    word = {opnd, cmd};
    #3;
    for (int i = 0; i < 20; i++) begin
      pclk = 1'b1;
      #5 pdat = word[i];
      #75 pclk = 1'b0;
      #80;
    end
    // hold time over: data no longer shows the last bit
    pdat = ~word[19];
  endtask
endmodule // prog_driver

// >>> bench/prog_port_checker_assertions.sv
// port assertions for the programming pin set arbiter
`timescale 1ns/1ns
module prog_port_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic std_hv_detect,
  input wire logic alt_hv_detect,
  input wire logic alt_lv_entry,
  input wire logic std_pins_repurposed,
  input wire logic program_data_oe,
  input wire logic alt_program_data_oe,
  input wire logic reset_request,
  input wire logic shared_general_input,
  input wire logic frame_valid,
  input wire logic [1:0] session_owner,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================================
  // session ownership
  // an owner never passes straight to the other set
  property p_std_kept; session_owner == 2'b01 |=> session_owner != 2'b11; endproperty
  a_std_kept: assert property (p_std_kept) else $error("standard session lost");
  property p_alt_kept; session_owner == 2'b11 |=> session_owner != 2'b01; endproperty
  a_alt_kept: assert property (p_alt_kept) else $error("dedicated session lost");
  // 8 cycles covers sync latency plus a dedicated exit
  property p_std_entry;
    (std_hv_detect && !std_pins_repurposed && !alt_hv_detect && !alt_lv_entry) [*8]
      |-> session_owner == 2'b01;
  endproperty
  a_std_entry: assert property (p_std_entry) else $error("standard entry missed");
  property p_repurposed;
    std_pins_repurposed [*4] ##0 session_owner == 2'b00 |=> session_owner != 2'b01;
  endproperty
  a_repurposed: assert property (p_repurposed) else $error("repurposed pins entered");
  // ==========================================================
  // pin drivers and frames
  property p_alt_oe; alt_program_data_oe |-> session_owner == 2'b11; endproperty
  a_alt_oe: assert property (p_alt_oe) else $error("dedicated data driven");
  property p_std_oe; program_data_oe |-> session_owner == 2'b01; endproperty
  a_std_oe: assert property (p_std_oe) else $error("standard data driven");
  property p_frame_pulse; frame_valid |=> !frame_valid; endproperty
  a_frame_pulse: assert property (p_frame_pulse) else $error("frame pulse too long");
  property p_frame_owned; frame_valid |-> session_owner != 2'b00; endproperty
  a_frame_owned: assert property (p_frame_owned) else $error("frame outside session");
  // ==========================================================
  // reset pin and register port
  property p_rst_excl; reset_request |-> !shared_general_input && session_owner == 2'b00; endproperty
  a_rst_excl: assert property (p_rst_excl) else $error("reset and input both active");
  property p_rdata_idle; !$past(reg_read) |-> reg_rdata == 16'h0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  c_std: cover property (session_owner == 2'b01);
  c_alt: cover property (session_owner == 2'b11);
  c_frame: cover property (frame_valid);
endmodule // prog_port_checker
bind prog_port_select prog_port_checker prog_port_checker_inst (.clock, .rst, .std_hv_detect,
  .alt_hv_detect, .alt_lv_entry, .std_pins_repurposed, .program_data_oe, .alt_program_data_oe,
  .reset_request, .shared_general_input, .frame_valid, .session_owner, .reg_read, .reg_rdata);

// >>> bench/tb_top.sv
// self-checking bench for the programming port selector
`timescale 1ns/1ns
`include "prog_port_cfg.svh"
module tb_top;
  logic clock, rst, std_rep, std_lv, alt_lv, rst_pin_n;
  logic reg_write, reg_read;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, frame_operand, d;
  logic std_en, std_clk, std_dat, alt_en, alt_clk, alt_dat;
  logic p_out, p_oe, a_out, a_oe, reset_request, shared_general_input, frame_valid;
  logic [3:0] frame_cmd;
  logic [1:0] session_owner;
  prog_port_pkg::variant_t variant;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  int std_drive = 0;
  int alt_drive = 0;
  logic [7:0] reply;
  // ==========================================================
  // clock, timeout and wiring
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // hang guard, far above the thousand or so cycles needed
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      results();
    end
  end
  // clocks in which each set's data pin is driven by the device
  always @(posedge clock) begin
    if (p_oe === 1'b1) std_drive++;
    if (a_oe === 1'b1) alt_drive++;
  end
  prog_driver prog_driver_std (.entry(std_en), .pclk(std_clk), .pdat(std_dat));
  prog_driver prog_driver_alt (.entry(alt_en), .pclk(alt_clk), .pdat(alt_dat));
  prog_port_select prog_port_select_inst (.clock(clock), .rst(rst), .std_hv_detect(std_en),
    .std_lv_entry(std_lv), .program_clock_pin(std_clk),
    .program_data_pin(p_oe ? p_out : std_dat), .program_data_out(p_out),
    .program_data_oe(p_oe), .std_pins_repurposed(std_rep), .alt_hv_detect(alt_en),
    .alt_lv_entry(alt_lv), .alt_program_clock_pin(alt_clk),
    .alt_program_data_pin(a_oe ? a_out : alt_dat), .alt_program_data_out(a_out),
    .alt_program_data_oe(a_oe), .external_reset_pin_n(rst_pin_n),
    .reset_request(reset_request), .shared_general_input(shared_general_input),
    .reply_byte(reply), .variant(variant), .frame_valid(frame_valid), .frame_cmd(frame_cmd),
    .frame_operand(frame_operand), .session_owner(session_owner), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
  // ==========================================================
  // shared tasks
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task wait_owner(input logic [1:0] exp);
    for (int n = 0; n < 60 && session_owner !== exp; n++) @(posedge clock);
    #1 check(16'(session_owner), 16'(exp));
  endtask
  task get_frame(input logic [3:0] c, input logic [15:0] o);
    repeat (400) begin
      @(posedge clock);
      #1;
      if (frame_valid === 1'b1) break;
    end
    check(16'(frame_valid), 16'h0001);
    check(16'(frame_cmd), 16'(c));
    check(frame_operand, o);
  endtask
  // ==========================================================
  // scenarios
  task t_standard;
    rd(`ADDR_CONFIG);
    check(d, 16'h0007);
    rd(4'hf);
    check(d, 16'h0000);
    wr(`ADDR_CONFIG, 16'h0006);
    rd(`ADDR_CONFIG);
    check(d, 16'h0007);
    prog_driver_std.enter(1'b1);
    wait_owner(2'b01);
    prog_driver_alt.enter(1'b1);
    repeat (20) @(posedge clock);
    check(16'(session_owner), 16'h0001);
    prog_driver_alt.enter(1'b0);
    fork
      prog_driver_std.send(4'hd, 16'h3c40);
      get_frame(4'hd, 16'h3c40);
    join
    // output half: the device answers on the upper operand byte
    reply <= 8'hc5;
    fork
      prog_driver_std.send(4'h2, 16'h0096);
      get_frame(4'h2, 16'hc596);
    join
    check(16'(p_oe), 16'h0000);
    check(16'(std_drive != 0 && alt_drive == 0), 16'h0001);
    wr(`ADDR_CONFIG, 16'h0006); // small-package programmer clears it
    rd(`ADDR_CONFIG);
    check(d, 16'h0006);
    prog_driver_std.enter(1'b0);
    wait_owner(2'b00);
    prog_driver_alt.enter(1'b1);
    repeat (20) @(posedge clock);
    check(16'(session_owner), 16'h0000);
    prog_driver_alt.enter(1'b0);
    prog_driver_std.enter(1'b1);
    wait_owner(2'b01);
    wr(`ADDR_CONFIG, 16'h0007);
    prog_driver_std.enter(1'b0);
    wait_owner(2'b00);
  endtask
  task t_dedicated;
    int s;
    prog_driver_alt.enter(1'b1);
    wait_owner(2'b11);
    prog_driver_std.enter(1'b1);
    fork
      prog_driver_alt.send(4'h1, 16'ha5c3);
      get_frame(4'h1, 16'ha5c3);
    join
    s = std_drive;
    reply <= 8'h3c;
    fork
      prog_driver_alt.send(4'ha, 16'h0069);
      get_frame(4'ha, 16'h3c69);
    join
    check(16'(a_oe), 16'h0000);
    check(16'(alt_drive != 0 && std_drive == s), 16'h0001);
    check(16'(session_owner), 16'h0003);
    prog_driver_std.enter(1'b0);
    prog_driver_alt.enter(1'b0);
    wait_owner(2'b00);
    alt_lv <= 1'b1;
    wait_owner(2'b11);
    std_lv <= 1'b1;
    repeat (10) @(posedge clock);
    check(16'(session_owner), 16'h0003);
    std_lv <= 1'b0;
    alt_lv <= 1'b0;
    wait_owner(2'b00);
    std_rep <= 1'b1;
    prog_driver_std.enter(1'b1);
    repeat (20) @(posedge clock);
    check(16'(session_owner), 16'h0000);
    prog_driver_std.enter(1'b0);
    std_rep <= 1'b0;
  endtask
  task t_reset_pin;
    rst_pin_n <= 1'b0;
    wr(`ADDR_CONFIG, 16'h0003);
    repeat (4) @(posedge clock);
    #1 check({reset_request, shared_general_input}, 16'h0002);
    wr(`ADDR_CONFIG, 16'h0001);
    rst_pin_n <= 1'b1;
    repeat (4) @(posedge clock);
    #1 check({reset_request, shared_general_input}, 16'h0001);
    prog_driver_std.enter(1'b1);
    wait_owner(2'b01);
    wr(`ADDR_CONFIG, 16'h0000);
    rd(`ADDR_CONFIG);
    check(d, 16'h0000);
    prog_driver_std.enter(1'b0);
    wait_owner(2'b00);
    // second reset in mid-run: every configuration bit returns to set
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(`ADDR_CONFIG);
    check(d, 16'h0007);
  endtask
  task t_region;
    logic [15:0] last, a, e;
    logic [3:0] sh;
    for (int v = 0; v < 3; v++) begin
      variant <= prog_port_pkg::variant_t'(v);
      last = v == 0 ? `LAST_16K : v == 1 ? `LAST_32K : `LAST_64K;
      sh = v == 0 ? `SHIFT_16K : v == 1 ? `SHIFT_32K : `SHIFT_64K;
      for (int i = 0; i < 10; i++) begin
        a = i[0] ? 16'h07ff << i[3:1] | 16'h07ff : 16'h0800 << i[3:1];
        wr(`ADDR_REGION, a);
        rd(`ADDR_REGION);
        e = {12'h000, a <= last, a <= `BOOT_LAST, 2'(a >> sh)};
        check(d, e);
      end
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {rst, std_rep, std_lv, alt_lv, reg_write, reg_read} = 6'h20;
    rst_pin_n = 1'b1;
    reply = 8'h00;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    variant = prog_port_pkg::size_16k;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_standard();
    t_dedicated();
    t_reset_pin();
    t_region();
    results();
  end
endmodule // tb_top

// >>> rtl/code_region.sv
// code memory region decoder for protection boundaries
`timescale 1ns/1ns
`include "prog_port_cfg.svh"
module code_region (
  input wire prog_port_pkg::variant_t variant,
  input wire logic [15:0] addr,
  output logic in_boot,
  output logic in_range,
  output logic [1:0] block_num
);
  // ==========================================================
  // decode helpers
  // last implemented address for a variant
  function automatic logic [15:0] last_addr(input prog_port_pkg::variant_t v);
    case (v)
      prog_port_pkg::size_16k: last_addr = `LAST_16K;
      prog_port_pkg::size_32k: last_addr = `LAST_32K;
      default: last_addr = `LAST_64K;
    endcase
  endfunction
  // block index from block size
  function automatic logic [1:0] block_of(input prog_port_pkg::variant_t v,
                                          input logic [15:0] a);
    case (v)
      prog_port_pkg::size_16k: block_of = a[13:12]; // 4k blocks
      prog_port_pkg::size_32k: block_of = a[14:13]; // 8k blocks
      default: block_of = a[15:14]; // 16k blocks
    endcase
  endfunction
  // ==========================================================
  // region outputs
  assign in_range = (addr <= last_addr(variant)); // above top: out of range, block_num still decoded
  assign in_boot = in_range && (addr <= `BOOT_LAST); // boot apart from block 0
  assign block_num = block_of(variant, addr);
endmodule // code_region

// >>> rtl/pin_sync.sv
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  // ==========================================================
  // synchroniser stages
  logic [WIDTH-1:0] meta_ff; // first stage, read only by second
  logic [WIDTH-1:0] sync_ff; // second stage, safe to use
  // both stages clear on reset
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end
  assign pin_out = sync_ff;
endmodule // pin_sync

// >>> rtl/prog_port_cfg.svh
// constants for the programming port selector and code region decoder
`ifndef PROG_PORT_CFG_SVH
`define PROG_PORT_CFG_SVH
// ==========================================================
// configuration defaults
`define DEDICATED_PORT_RESET 1'b1
// ==========================================================
// serial frame layout
`define FRAME_BITS 5'd20
`define CMD_BITS 5'd4
// ==========================================================
// code memory map
`define BOOT_LAST 16'h07ff
`define LAST_16K 16'h3fff
`define LAST_32K 16'h7fff
`define LAST_64K 16'hffff
`define SHIFT_16K 4'd12
`define SHIFT_32K 4'd13
`define SHIFT_64K 4'd14
// ==========================================================
// register bus
`define ADDR_CONFIG 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_FRAME_LO 4'h2
`define ADDR_FRAME_HI 4'h3
`define ADDR_REGION 4'h4
`define CFG_DEDICATED_BIT 0
`define CFG_LOW_VOLT_BIT 1
`define CFG_RESET_FUNC_BIT 2
`endif

// >>> rtl/prog_port_pkg.sv
// types shared by the programming port selector
package prog_port_pkg;
  // which pin set owns the current session
  typedef enum logic [1:0] {
    owner_none = 2'b00,
    owner_standard = 2'b01,
    owner_dedicated = 2'b11
  } owner_t;
  // code memory size variant
  typedef enum logic [1:0] {
    size_16k = 2'b00,
    size_32k = 2'b01,
    size_64k = 2'b10
  } variant_t;
endpackage

// >>> rtl/prog_port_select.sv
// programming pin set arbiter, serial frame receiver and register port
//
// Summary of operation
// - dedicated disabled: dedicated pins unused, floating
// - dedicated enable resets to set
// - dedicated set behaves like standard set
// - standard set works unless firmware repurposes
// - first enable pin to enter wins
// - dedicated first: ignore standard enable
// - standard first: ignore dedicated enable
// - same priority for low-voltage entry
// - dedicated bit written only via standard session
// - high-voltage entry always allowed
// - low-voltage entry forces reset pin function
// - 16k variant: 4k blocks to 3fff
// - boot region 0 to 7ff separate
// - 32k variant: four 8k blocks
// - 64k variant: four 16k blocks
// - sample data on clock fall, lsb first
// - frame is 4-bit command, 16-bit operand
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ns
`include "prog_port_cfg.svh"
module prog_port_select (
  input wire logic clock,
  input wire logic rst,
  // standard pin set
  input wire logic std_hv_detect, // high programming voltage seen on enable pin
  input wire logic std_lv_entry, // low-voltage key accepted on standard set
  input wire logic program_clock_pin,
  input wire logic program_data_pin,
  output logic program_data_out,
  output logic program_data_oe,
  input wire logic std_pins_repurposed, // firmware gave pins another function
  // dedicated pin set
  input wire logic alt_hv_detect,
  input wire logic alt_lv_entry,
  input wire logic alt_program_clock_pin,
  input wire logic alt_program_data_pin,
  output logic alt_program_data_out,
  output logic alt_program_data_oe,
  // reset pin
  input wire logic external_reset_pin_n,
  output logic reset_request,
  output logic shared_general_input,
  // output byte to shift back during output phase
  input wire logic [7:0] reply_byte,
  // variant of code memory
  input wire prog_port_pkg::variant_t variant,
  // frame out
  output logic frame_valid,
  output logic [3:0] frame_cmd,
  output logic [15:0] frame_operand,
  output logic [1:0] session_owner,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata
);
  // ==========================================================
  // pin synchronisers
  // every programmer pin is asynchronous to clock, so all nine pass the
  // same two stages; one bundle keeps link clock and data aligned,
  // which the falling-edge sampler below depends on
  logic [8:0] pins_raw;
  logic [8:0] pins_s;
  assign pins_raw = {std_hv_detect, std_lv_entry, program_clock_pin, program_data_pin,
                     alt_hv_detect, alt_lv_entry, alt_program_clock_pin,
                     alt_program_data_pin, external_reset_pin_n};
  pin_sync #(.WIDTH(9)) u_sync (
    .clock(clock),
    .rst(rst),
    .pin_in(pins_raw),
    .pin_out(pins_s)
  );
  wire std_hv = pins_s[8];
  wire std_lv = pins_s[7];
  wire std_clk = pins_s[6];
  wire std_dat = pins_s[5];
  wire alt_hv = pins_s[4];
  wire alt_lv = pins_s[3];
  wire alt_clk = pins_s[2];
  wire alt_dat = pins_s[1];
  wire rst_pin_n = pins_s[0];
  // ==========================================================
  // configuration bits
  logic dedicated_port_enable_ff; // dedicated set allowed
  logic low_voltage_entry_enable_ff; // low-voltage key entry allowed
  logic reset_pin_function_enable_ff; // reset pin acts as reset
  prog_port_pkg::owner_t owner_ff;
  prog_port_pkg::owner_t nxt_owner;
  // entry requests per set; high voltage needs no low-voltage enable bit
  wire std_enter = std_hv | (low_voltage_entry_enable_ff & std_lv);
  wire alt_avail = dedicated_port_enable_ff; // off: dedicated pins ignored
  wire alt_enter = alt_avail & (alt_hv | (low_voltage_entry_enable_ff & alt_lv));
  wire std_avail = ~std_pins_repurposed;
  wire std_req = std_enter & std_avail;
  // ==========================================================
  // arbitration: first arrival wins, held for session
  // both requests see equal synchroniser delays, so arrival order is
  // kept to within one clock; a true tie goes to the standard set,
  // since that set can be used for programming unless firmware repurposes it
  always_comb begin
    nxt_owner = owner_ff;
    case (owner_ff)
      prog_port_pkg::owner_none: begin
        if (std_req) begin // standard first, or tie, wins
          nxt_owner = prog_port_pkg::owner_standard;
        end else if (alt_enter) begin // dedicated first
          nxt_owner = prog_port_pkg::owner_dedicated;
        end
      end
      prog_port_pkg::owner_standard: begin
        if (!std_enter) begin // exit re-arms arbitration
          nxt_owner = prog_port_pkg::owner_none;
        end
      end
      prog_port_pkg::owner_dedicated: begin
        if (!alt_enter) begin // other enable ignored meanwhile
          nxt_owner = prog_port_pkg::owner_none;
        end
      end
      default: nxt_owner = prog_port_pkg::owner_none;
    endcase
  end
  // owner register
  always_ff @(posedge clock) begin
    if (rst) begin
      owner_ff <= prog_port_pkg::owner_none;
    end else begin
      owner_ff <= nxt_owner;
    end
  end
  wire in_session = (owner_ff != prog_port_pkg::owner_none);
  wire use_alt = (owner_ff == prog_port_pkg::owner_dedicated);
  assign session_owner = owner_ff;
  // ==========================================================
  // selected link; same receiver for either set
  // one receiver serves both sets, so the dedicated set cannot drift
  // from the standard set in timing or bit order
  // edge finding needs a link half-period of at least three clocks
  wire sel_clk = use_alt ? alt_clk : std_clk;
  wire sel_dat = use_alt ? alt_dat : std_dat;
  logic clk_d_ff; // previous clock level for edge finding
  always_ff @(posedge clock) begin
    if (rst) begin
      clk_d_ff <= 1'b0;
    end else begin
      clk_d_ff <= sel_clk;
    end
  end
  wire fall = in_session & clk_d_ff & ~sel_clk; // sample point
  wire rise = in_session & ~clk_d_ff & sel_clk;
  // ==========================================================
  // frame shifter
  // a frame left half-way when the session ends is thrown away: the
  // counter clears with the owner, so the next entry starts at bit 0
  logic [19:0] shift_ff;
  logic [4:0] count_ff;
  logic [7:0] reply_ff;
  logic frame_valid_ff;
  logic [3:0] cmd_ff;
  logic [15:0] operand_ff;
  logic out_en_ff; // drive data pin during output half
  logic out_bit_ff;
  wire last_bit = (count_ff == `FRAME_BITS - 5'd1);
  wire out_phase = (count_ff >= `CMD_BITS + 5'd8) && (cmd_ff[1] == 1'b1);
  // lsb-first shift, 20 bits per frame
  always_ff @(posedge clock) begin
    if (rst || !in_session) begin
      shift_ff <= 20'h00000;
      count_ff <= 5'd0;
      frame_valid_ff <= 1'b0;
      cmd_ff <= 4'h0;
      operand_ff <= 16'h0000;
    end else begin
      frame_valid_ff <= 1'b0;
      if (fall) begin
        shift_ff <= {sel_dat, shift_ff[19:1]};
        if (count_ff == `CMD_BITS - 5'd1) begin
          cmd_ff <= {sel_dat, shift_ff[19:17]}; // command known early
        end
        if (last_bit) begin
          count_ff <= 5'd0;
          frame_valid_ff <= 1'b1;
          operand_ff <= {sel_dat, shift_ff[19:5]};
        end else begin
          count_ff <= count_ff + 5'd1;
        end
      end
    end
  end
  // output half: drive reply bits after rising edge, lsb first
  // the reply byte is taken at the twelfth fall, the last input bit, so
  // the core has the whole input half to prepare it
  // the driver lets go at the last fall of the frame; otherwise the pin
  // would stay driven while the link clock idles low between frames
  always_ff @(posedge clock) begin
    if (rst || !in_session) begin
      // no session: pin released and the reply forgotten
      reply_ff <= 8'h00;
      out_en_ff <= 1'b0;
      out_bit_ff <= 1'b0;
    end else if (fall && count_ff == `CMD_BITS + 5'd7) begin
      // capture before the first output bit is due
      reply_ff <= reply_byte;
    end else if (fall && last_bit) begin
      // frame over: stop driving
      out_en_ff <= 1'b0;
    end else if (rise) begin
      // enable follows the phase at every rise
      out_en_ff <= out_phase;
      out_bit_ff <= reply_ff[0];
      if (out_phase) begin
        reply_ff <= {1'b0, reply_ff[7:1]};
      end
    end
  end
  assign frame_valid = frame_valid_ff;
  assign frame_cmd = cmd_ff;
  assign frame_operand = operand_ff;
  // only the owning set drives; dedicated pins float otherwise
  assign program_data_out = out_bit_ff;
  // qualified by the session too: the enable register clears one clock
  // after the owner does, and the pin must not be driven in that gap
  assign program_data_oe = out_en_ff & in_session & ~use_alt;
  assign alt_program_data_out = out_bit_ff;
  assign alt_program_data_oe = out_en_ff & use_alt;
  // ==========================================================
  // reset pin function
  // the reset request is masked during a session, because the same pin
  // doubles as the standard programming enable
  wire lv_session = low_voltage_entry_enable_ff; // low-voltage entry forces reset
  wire reset_func = reset_pin_function_enable_ff | lv_session;
  assign reset_request = reset_func & ~rst_pin_n & ~in_session;
  assign shared_general_input = reset_func ? 1'b0 : rst_pin_n;
  // ==========================================================
  // code region for register readback
  logic [15:0] region_addr_ff;
  logic r_boot;
  logic r_range;
  logic [1:0] r_block;
  code_region u_region (
    .variant(variant),
    .addr(region_addr_ff),
    .in_boot(r_boot),
    .in_range(r_range),
    .block_num(r_block)
  );
  // ==========================================================
  // configuration register writes
  // low-voltage and reset-function bits are writable at any time; only
  // the dedicated enable is guarded, since clearing it from the
  // dedicated set would cut the link in use
  wire cfg_wr = reg_write && (reg_addr == `ADDR_CONFIG);
  wire std_owner = (owner_ff == prog_port_pkg::owner_standard);
  always_ff @(posedge clock) begin
    if (rst) begin
      dedicated_port_enable_ff <= `DEDICATED_PORT_RESET; // set after reset
      low_voltage_entry_enable_ff <= 1'b1;
      reset_pin_function_enable_ff <= 1'b1;
      region_addr_ff <= 16'h0000;
    end else begin
      if (cfg_wr) begin
        if (std_owner) begin // only via standard session
          dedicated_port_enable_ff <= reg_wdata[`CFG_DEDICATED_BIT];
        end
        low_voltage_entry_enable_ff <= reg_wdata[`CFG_LOW_VOLT_BIT];
        reset_pin_function_enable_ff <= reg_wdata[`CFG_RESET_FUNC_BIT];
      end
      if (reg_write && reg_addr == `ADDR_REGION) begin
        region_addr_ff <= reg_wdata;
      end
    end
  end
  // ==========================================================
  // read mux, data one cycle after strobe
  // rdata falls back to zero when no read is pending, so a stale word
  // is never mistaken for a fresh answer
  logic [15:0] rd_mux;
  assign rd_mux = (reg_addr == `ADDR_CONFIG) ? {13'h0000, reset_pin_function_enable_ff,
                    low_voltage_entry_enable_ff, dedicated_port_enable_ff} :
                  (reg_addr == `ADDR_STATUS) ? {14'h0000, owner_ff} :
                  (reg_addr == `ADDR_FRAME_LO) ? operand_ff :
                  (reg_addr == `ADDR_FRAME_HI) ? {12'h000, cmd_ff} :
                  (reg_addr == `ADDR_REGION) ? {12'h000, r_range, r_boot, r_block} :
                  16'h0000;
  logic [15:0] rdata_ff;
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_ff <= 16'h0000;
    end else if (reg_read) begin
      rdata_ff <= rd_mux;
    end else begin
      rdata_ff <= 16'h0000;
    end
  end
  assign reg_rdata = rdata_ff;
endmodule // prog_port_select
